// >>> hw/soc_cfg.svh
// Offsets, field positions, reset values and timing of the output control
`ifndef SOC_CFG_SVH
`define SOC_CFG_SVH
`define SOC_ADDR_W      8
`define SOC_CNT_W       24
`define SOC_TICK_W      21
`define SOC_OFS_CTRL    8'h00
`define SOC_OFS_PRESET  8'h04
`define SOC_OFS_SCALE   8'h08
`define SOC_OFS_DELAY   8'h0C
`define SOC_OFS_STATUS  8'h10
`define SOC_OFS_TIMER   8'h14
`define SOC_CTRL_MODE   0
`define SOC_CTRL_REV    3
`define SOC_CTRL_DZ     4
`define SOC_CTRL_LVL    8
`define SOC_CTRL_LVLNEG 11
`define SOC_RST_MODE    3'h3
`define SOC_RST_DZ      3'h4
`define SOC_RST_LVL     3'h1
`define SOC_RST_PRESET  21'h000000
`define SOC_RST_SCALE   17'h02710
`define SOC_RST_DELAY   16'h0064
`define SOC_PRESET_MAX  32'h000F423F
`define SOC_SCALE_MAX   32'h0000EA5F
`define SOC_DELAY_MAX   32'h0000EA5F
`define SOC_DISP_LIMIT  52'h0002540BBCF0
`define SOC_M_O1_START  3'h1
`define SOC_M_O1_END    3'h2
`define SOC_M_RST       3'h3
`define SOC_M_RST_END   3'h4
`define SOC_M_DELAY     3'h5
`define SOC_M_BOUNDARY  3'h6
`define SOC_LVL_NONE    3'h1
`define SOC_LVL_PRESET  3'h2
`define SOC_LVL_SCALE   3'h3
`define SOC_LVL_BOTH    3'h4
`define SOC_RESP_OKAY   2'h0
`define SOC_RESP_SLVERR 2'h2
`define SOC_RESP_DECERR 2'h3
`define SOC_TICK_NS     10000000
`define SOC_CLK_NS      8
`endif

// >>> hw/soc_pkg.sv
// State type of the second output control block
`include "soc_cfg.svh"
package soc_pkg;
  typedef struct packed {
    logic [3:0]                    sy1;
    logic [3:0]                    sy2;
    logic                          mrst_q;
    logic                          out1_q;
    logic                          eq_q;
    logic                          init;
    logic                          pu_hold;
    logic                          act;
    logic [2:0]                    mode;
    logic                          rev;
    logic [2:0]                    dz;
    logic [2:0]                    lvl;
    logic                          lvl_neg;
    logic signed [20:0]            preset;
    logic signed [16:0]            scale;
    logic [15:0]                   delay;
    logic [15:0]                   tmr;
    logic                          tmr_run;
    logic [`SOC_TICK_W-1:0]        tick;
    logic                          out2;
    logic                          relay2;
    logic                          bmem;
    logic                          ovf;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic                          aw_have;
    logic                          w_have;
    logic [`SOC_ADDR_W-1:0]        aw_addr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
  } soc_state_t;
endpackage

// >>> hw/soc_second_output.sv
// Second preset output control with AXI4-Lite configuration
`timescale 1ns/1ps
`include "soc_cfg.svh"
module soc_second_output #(
  parameter int TICK_CYC = `SOC_TICK_NS / `SOC_CLK_NS
) (
  // Clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  // Counter side
  input  wire logic signed [`SOC_CNT_W-1:0]  count_i,
  input  wire logic                          out1_i,
  input  wire logic                          restore_i,
  // Pins, active low where named so
  input  wire logic                          fp_rst_n_i,
  input  wire logic                          remote_rst_n_i,
  input  wire logic                          program_lockout_input_n_i,
  input  wire logic                          fp_rst_dis_i,
  // Output pins and status
  output logic                               out2_o,
  output logic                               relay2_o,
  output logic                               boundary_mem_o,
  output logic                               overflow_o,
  // AXI4-Lite write
  input  wire logic [`SOC_ADDR_W-1:0]        awaddr_i,
  input  wire logic                          awvalid_i,
  output logic                               awready_o,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic [3:0]                    wstrb_i,
  input  wire logic                          wvalid_i,
  output logic                               wready_o,
  output logic [1:0]                         bresp_o,
  output logic                               bvalid_o,
  input  wire logic                          bready_i,
  // AXI4-Lite read
  input  wire logic [`SOC_ADDR_W-1:0]        araddr_i,
  input  wire logic                          arvalid_i,
  output logic                               arready_o,
  output logic [31:0]                        rdata_o,
  output logic [1:0]                         rresp_o,
  output logic                               rvalid_o,
  input  wire logic                          rready_i
);
  import soc_pkg::*;

  localparam logic [`SOC_TICK_W-1:0] TICK_LAST =
    `SOC_TICK_W'(TICK_CYC - 1);

  initial begin
    if (TICK_CYC < 1 || TICK_CYC > (1 << `SOC_TICK_W))
      $error("TICK_CYC out of range");
  end

  soc_state_t st;
  soc_state_t n;

  logic                   lock;
  logic                   mrst;
  logic                   rst_rise;
  logic                   rst_fall;
  logic                   o1_rise;
  logic                   o1_fall;
  logic                   reach;
  logic                   ge;
  logic                   set;
  logic                   clr;
  logic                   load;
  logic                   expire;
  logic                   do_wr;
  logic [31:0]            wv;
  logic [33:0]            rd_w;
  logic [33:0]            rd_r;
  logic [51:0]            prod;
  logic                   ovf_raw;
  logic signed [31:0]     ws;

  // Register read: response and word
  function automatic logic [33:0] reg_rd(input logic [`SOC_ADDR_W-1:0] a,
                                         input soc_state_t s,
                                         input logic lk);
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h00000000;
    r = `SOC_RESP_OKAY;
    unique case ({a[`SOC_ADDR_W-1:2], 2'b00})
      `SOC_OFS_CTRL: begin
        d[`SOC_CTRL_MODE +: 3] = s.mode;
        d[`SOC_CTRL_REV]       = s.rev;
        d[`SOC_CTRL_DZ +: 3]   = s.dz;
        d[`SOC_CTRL_LVL +: 3]  = s.lvl;
        d[`SOC_CTRL_LVLNEG]    = s.lvl_neg;
      end
      `SOC_OFS_PRESET: d = 32'(s.preset);
      `SOC_OFS_SCALE:  d = 32'(s.scale);
      `SOC_OFS_DELAY:  d[15:0] = s.delay;
      `SOC_OFS_STATUS: d[6:0] = {s.pu_hold, s.mrst_q, lk, s.tmr_run,
                                 s.ovf, s.out2, s.act};
      `SOC_OFS_TIMER:  d[15:0] = s.tmr;
      default:         r = `SOC_RESP_DECERR;
    endcase
    return {r, d};
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0]  b);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        m[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Magnitude of a signed value
  function automatic logic [23:0] mag(input logic signed [23:0] v);
    return v[23] ? 24'(-v) : 24'(v);
  endfunction

  function automatic logic [9:0] pow10(input logic [2:0] dz);
    unique case (dz)
      3'h1:    pow10 = 10'h00A;
      3'h2:    pow10 = 10'h064;
      3'h3:    pow10 = 10'h3E8;
      default: pow10 = 10'h001;
    endcase
  endfunction

  always_comb begin
    n = st;
    n.init = 1'b0;
    // Two-stage pin synchronisers
    n.sy1 = {fp_rst_dis_i, program_lockout_input_n_i, remote_rst_n_i,
             fp_rst_n_i};
    n.sy2 = st.sy1;
    lock = ~st.sy2[2];
    // Reset gating by level sign and switch
    mrst = !(lock && st.lvl_neg) &&
           (~st.sy2[1] || (~st.sy2[0] && ~st.sy2[3]));
    n.mrst_q = mrst;
    rst_rise = mrst && !st.mrst_q;
    rst_fall = !mrst && st.mrst_q;
    n.out1_q = out1_i;
    o1_rise = out1_i && !st.out1_q;
    o1_fall = !out1_i && st.out1_q;
    ge = (st.preset < 0) ? (count_i <= `SOC_CNT_W'(st.preset))
                         : (count_i >= `SOC_CNT_W'(st.preset));
    n.eq_q = count_i == `SOC_CNT_W'(st.preset);
    // Activate on reaching, never at power-up
    reach = n.eq_q && !st.eq_q && !st.init;
    set = reach;
    expire = 1'b0;
    if (st.tmr_run) begin
      if (st.tick == TICK_LAST) begin
        n.tick = '0;
        n.tmr = st.tmr - 16'h0001;
        if (st.tmr == 16'h0001) begin
          n.tmr_run = 1'b0;
          expire = 1'b1;
        end
      end else begin
        n.tick = st.tick + `SOC_TICK_W'(1);
      end
    end
    if (mrst) begin
      n.tmr_run = 1'b0;
    end
    clr = 1'b0;
    unique case (st.mode)
      `SOC_M_O1_START: clr = o1_rise;
      `SOC_M_O1_END:   clr = o1_fall;
      `SOC_M_RST:      clr = rst_rise;
      `SOC_M_RST_END:  clr = rst_fall;
      // End on expiry or manual reset
      `SOC_M_DELAY:    clr = expire || mrst;
      default:         clr = 1'b0;
    endcase
    load = (st.mode == `SOC_M_DELAY) && set && !st.act;
    if (load) begin
      n.tmr = st.delay;
      n.tick = '0;
      n.tmr_run = 1'b1;
    end
    if (st.mode == `SOC_M_BOUNDARY) begin
      n.act = st.init ? restore_i : ge;
    end else if (set) begin
      n.act = 1'b1;
    end else if (clr) begin
      n.act = 1'b0;
    end
    if (mrst || set) begin
      n.pu_hold = 1'b0;
    end
    // Display overflow from scale and dummy zeros
    prod = 52'(mag(count_i)) * 52'(mag(24'(st.scale))) * 52'(pow10(st.dz));
    ovf_raw = prod > `SOC_DISP_LIMIT;
    n.ovf = ovf_raw;
    // AXI write channel
    if (awvalid_i && st.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr_i;
    end
    if (wvalid_i && st.wready) begin
      n.w_have = 1'b1;
      n.wdata = wdata_i;
      n.wstrb = wstrb_i;
    end
    if (st.bvalid && bready_i) begin
      n.bvalid = 1'b0;
    end
    do_wr = st.aw_have && st.w_have && !st.bvalid;
    rd_w = reg_rd(st.aw_addr, st, lock);
    wv = merge(rd_w[31:0], st.wdata, st.wstrb);
    ws = wv;
    if (do_wr) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SOC_RESP_OKAY;
      unique case ({st.aw_addr[`SOC_ADDR_W-1:2], 2'b00})
        `SOC_OFS_CTRL: begin
          if (lock ||
              wv[`SOC_CTRL_MODE +: 3] < `SOC_M_O1_START ||
              wv[`SOC_CTRL_MODE +: 3] > `SOC_M_BOUNDARY ||
              wv[`SOC_CTRL_DZ +: 3] < 3'h1 || wv[`SOC_CTRL_DZ +: 3] > 3'h4 ||
              wv[`SOC_CTRL_LVL +: 3] < `SOC_LVL_NONE ||
              wv[`SOC_CTRL_LVL +: 3] > `SOC_LVL_BOTH) begin
            n.bresp = `SOC_RESP_SLVERR;
          end else begin
            n.mode = wv[`SOC_CTRL_MODE +: 3];
            n.rev = wv[`SOC_CTRL_REV];
            n.dz = wv[`SOC_CTRL_DZ +: 3];
            n.lvl = wv[`SOC_CTRL_LVL +: 3];
            n.lvl_neg = wv[`SOC_CTRL_LVLNEG];
          end
        end
        `SOC_OFS_PRESET: begin
          if ((lock && st.lvl != `SOC_LVL_PRESET &&
               st.lvl != `SOC_LVL_BOTH) ||
              ws > $signed(`SOC_PRESET_MAX) ||
              ws < -$signed(`SOC_PRESET_MAX)) begin
            n.bresp = `SOC_RESP_SLVERR;
          end else begin
            n.preset = 21'(ws);
          end
        end
        `SOC_OFS_SCALE: begin
          // Scale factor level and range check
          if ((lock && st.lvl != `SOC_LVL_SCALE &&
               st.lvl != `SOC_LVL_BOTH) ||
              ws > $signed(`SOC_SCALE_MAX) ||
              ws < -$signed(`SOC_SCALE_MAX)) begin
            n.bresp = `SOC_RESP_SLVERR;
          end else begin
            n.scale = 17'(ws);
          end
        end
        `SOC_OFS_DELAY: begin
          // Delay range, zero keeps old value
          if (lock || wv > `SOC_DELAY_MAX) begin
            n.bresp = `SOC_RESP_SLVERR;
          end else if (wv != 32'h00000000) begin
            n.delay = wv[15:0];
          end
        end
        `SOC_OFS_STATUS, `SOC_OFS_TIMER: n.bresp = `SOC_RESP_SLVERR;
        default: n.bresp = `SOC_RESP_DECERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    rd_r = reg_rd(araddr_i, st, lock);
    if (st.rvalid && rready_i) begin
      n.rvalid = 1'b0;
    end
    if (arvalid_i && st.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_r[31:0];
      n.rresp = rd_r[33:32];
    end
    n.arready = !n.rvalid && !(arvalid_i && st.arready);
    if (n.pu_hold && n.mode != `SOC_M_BOUNDARY) begin
      n.out2 = 1'b0;
    end else begin
      n.out2 = n.act ^ n.rev;
    end
    n.relay2 = n.out2;
    n.bmem = n.act;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.sy1 <= 4'h7;
      st.sy2 <= 4'h7;
      st.init <= 1'b1;
      st.pu_hold <= 1'b1;
      st.mode <= `SOC_RST_MODE;
      st.dz <= `SOC_RST_DZ;
      st.lvl <= `SOC_RST_LVL;
      st.preset <= `SOC_RST_PRESET;
      st.scale <= `SOC_RST_SCALE;
      st.delay <= `SOC_RST_DELAY;
    end else begin
      st <= n;
    end
  end

  assign out2_o = st.out2;
  assign relay2_o = st.relay2;
  assign boundary_mem_o = st.bmem;
  assign overflow_o = st.ovf;
  assign awready_o = st.awready;
  assign wready_o = st.wready;
  assign bvalid_o = st.bvalid;
  assign bresp_o = st.bresp;
  assign arready_o = st.arready;
  assign rvalid_o = st.rvalid;
  assign rdata_o = st.rdata;
  assign rresp_o = st.rresp;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  mode_legal_a: assert property (
    st.mode >= `SOC_M_O1_START && st.mode <= `SOC_M_BOUNDARY)
    else $error("mode out of range");
  phase_out_a: assert property (
    (!st.pu_hold || st.mode == `SOC_M_BOUNDARY) |->
    (st.out2 == (st.act ^ st.rev)) && (st.relay2 == st.out2))
    else $error("output phase wrong");
  powerup_off_a: assert property (
    (st.pu_hold && st.mode != `SOC_M_BOUNDARY) |-> !st.out2 && !st.relay2)
    else $error("output on before reset");
  o1_start_a: assert property (
    (st.mode == `SOC_M_O1_START && o1_rise && !reach) |=> !st.act)
    else $error("mode one not ended");
  rst_end_a: assert property (
    (st.mode == `SOC_M_RST_END && rst_fall && !reach) |=> !st.act)
    else $error("mode four not ended");
  boundary_cmp_a: assert property (
    (st.mode == `SOC_M_BOUNDARY && !st.init) |=>
    (st.mode != `SOC_M_BOUNDARY || st.act == $past(ge)))
    else $error("boundary state wrong");
  delay_load_a: assert property (
    load |=> st.tmr_run && st.tmr == $past(st.delay) && st.act)
    else $error("delay not loaded");
  delay_abort_a: assert property (
    (mrst && !load) |=> !st.tmr_run)
    else $error("delay not aborted");
  zero_delay_a: assert property (
    (do_wr && {st.aw_addr[`SOC_ADDR_W-1:2], 2'b00} == `SOC_OFS_DELAY &&
     wv == 32'h00000000) |=> st.delay == $past(st.delay))
    else $error("zero delay stored");
  lock_ctrl_a: assert property (
    (do_wr && lock &&
     {st.aw_addr[`SOC_ADDR_W-1:2], 2'b00} == `SOC_OFS_CTRL) |=>
    st.bvalid && st.bresp == `SOC_RESP_SLVERR && $stable(st.mode))
    else $error("locked write accepted");
  rst_gate_a: assert property (
    (lock && st.lvl_neg) |-> !mrst)
    else $error("reset not disabled");
  ovf_flag_a: assert property (
    ovf_raw |=> st.ovf)
    else $error("overflow not flagged");

  delay_end_c: cover property (st.mode == `SOC_M_DELAY && expire);
  boundary_c: cover property (st.mode == `SOC_M_BOUNDARY && $rose(st.act));
  locked_wr_c: cover property (do_wr && lock);
  reverse_c: cover property (st.rev && $fell(st.out2));
endmodule

// >>> verification/soc_panel_model.sv
// Operator panel, rear terminals and relay contact beside the output block
`timescale 1ns/1ps
module soc_panel_model (
  // Operator actions
  input  wire logic fp_press_i,
  input  wire logic remote_press_i,
  input  wire logic lock_i,
  input  wire logic fp_off_i,
  // Device pins
  input  wire logic relay2_i,
  output logic      fp_rst_n_o,
  output logic      remote_rst_n_o,
  output logic      program_lockout_input_n_o,
  output logic      fp_rst_dis_o,
  output logic      contact_o
);
  // Buttons and jumper pull their pins to common
  assign fp_rst_n_o                = !fp_press_i;
  assign remote_rst_n_o            = !remote_press_i;
  assign program_lockout_input_n_o = !lock_i;
  assign fp_rst_dis_o              = fp_off_i;
  // Normally open contact follows the relay drive
  assign contact_o                 = relay2_i;
endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the second output control block
`timescale 1ns/1ps
`include "soc_cfg.svh"
module tb_top;
  import soc_pkg::*;
  localparam logic [2:0] ON  = 3'h3;
  localparam logic [2:0] OFF = 3'h0;
  localparam logic [1:0] OK  = `SOC_RESP_OKAY;
  localparam logic [1:0] SLV = `SOC_RESP_SLVERR;
  logic                   core_clk_i;
  logic                   rst_n_i;
  logic signed [23:0]     count_i;
  logic                   out1_i;
  logic                   fpress;
  logic                   rpress;
  logic                   lock;
  logic                   fp_off;
  logic                   restore;
  logic                   fp_rst_n;
  logic                   remote_rst_n;
  logic                   lock_n;
  logic                   fp_dis;
  logic                   out2_o;
  logic                   relay2_o;
  logic                   overflow_o;
  logic [7:0]             awaddr_i;
  logic [7:0]             araddr_i;
  logic [31:0]            wdata_i;
  logic                   awvalid_i;
  logic                   wvalid_i;
  logic                   bready_i;
  logic                   arvalid_i;
  logic                   rready_i;
  logic                   awready_o;
  logic                   wready_o;
  logic                   bvalid_o;
  logic                   arready_o;
  logic                   rvalid_o;
  logic [1:0]             bresp_o;
  logic [1:0]             rresp_o;
  logic [31:0]            rdata_o;
  logic [34:0]            bus_q[$];
  logic [2:0]             pin_q[$];
  event                   pin_ev;
  int                     n_mismatch;
  int                     samples_checked;
  int                     seed;
  int                     c;
  int                     p;
  int                     lim;

  soc_second_output #(.TICK_CYC(4)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .count_i(count_i),
    .out1_i(out1_i), .restore_i(restore), .fp_rst_n_i(fp_rst_n),
    .remote_rst_n_i(remote_rst_n), .program_lockout_input_n_i(lock_n),
    .fp_rst_dis_i(fp_dis), .out2_o(out2_o), .relay2_o(relay2_o),
    .boundary_mem_o(), .overflow_o(overflow_o), .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(4'hF), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i));

  soc_panel_model panel (
    .fp_press_i(fpress), .remote_press_i(rpress), .lock_i(lock),
    .fp_off_i(fp_off), .relay2_i(relay2_o), .fp_rst_n_o(fp_rst_n),
    .remote_rst_n_o(remote_rst_n), .program_lockout_input_n_o(lock_n),
    .fp_rst_dis_o(fp_dis), .contact_o());

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = !core_clk_i;
  end

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One register access; the answer is noted for the response monitor
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] r);
    logic a_ok;
    logic w_ok;
    bus_q.push_back({wr, r, wr ? 32'h0 : d});
    a_ok = 1'b0;
    w_ok = !wr;
    @(posedge core_clk_i);
    awaddr_i  <= a;
    araddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= wr;
    wvalid_i  <= wr;
    bready_i  <= wr;
    arvalid_i <= !wr;
    rready_i  <= !wr;
    do begin
      @(posedge core_clk_i);
      if (awvalid_i && awready_o) begin
        a_ok = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_ok = 1'b1;
        wvalid_i <= 1'b0;
      end
      if (arvalid_i && arready_o) begin
        a_ok = 1'b1;
        arvalid_i <= 1'b0;
      end
    end while (!(a_ok && w_ok));
    while (!(wr ? bvalid_o : rvalid_o)) @(posedge core_clk_i);
    bready_i <= 1'b0;
    rready_i <= 1'b0;
  endtask

  // Expected overflow, relay and output levels after n cycles
  task automatic pin(input int n, input logic [2:0] e);
    repeat (n) @(posedge core_clk_i);
    pin_q.push_back(e);
    @(negedge core_clk_i);
    -> pin_ev;
  endtask

  task automatic cnt(input int v);
    @(posedge core_clk_i);
    count_i <= 24'(v);
  endtask

  task automatic cause(input int m, input logic v);
    @(posedge core_clk_i);
    if (m <= 2) out1_i <= v;
    else rpress <= v;
  endtask

  task automatic lk(input logic v);
    @(posedge core_clk_i);
    lock <= v;
    repeat (4) @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] cw(input logic [2:0] m, input logic r,
    input logic [2:0] z, input logic [2:0] l, input logic n);
    return {20'h0, n, l, 1'b0, z, r, m};
  endfunction

  always @(posedge core_clk_i)
    if ((bvalid_o && bready_i) || (rvalid_o && rready_i))
      check(bvalid_o && bready_i ? {1'b1, bresp_o, 32'h0}
            : {1'b0, rresp_o, rdata_o}, bus_q.pop_front());

  always @(pin_ev)
    check({32'h0, overflow_o, relay2_o, out2_o},
          {32'h0, pin_q.pop_front()});

  initial begin
    #200us;
    n_mismatch++;
    results();
  end

  initial begin
    {rst_n_i, out1_i, fpress, rpress, lock, fp_off, restore} = '0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {awaddr_i, araddr_i, wdata_i, count_i} = '0;
    seed = 43;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(0, `SOC_OFS_CTRL, 32'h143, OK);
    bus(0, `SOC_OFS_SCALE, 32'h2710, OK);
    bus(0, `SOC_OFS_DELAY, 32'h64, OK);
    bus(0, 8'h18, 32'h0, `SOC_RESP_DECERR);
    pin(2, OFF);
    bus(1, `SOC_OFS_PRESET, 32'd1000000, SLV);
    bus(1, `SOC_OFS_PRESET, 32'hFFF0BDC1, OK);
    bus(1, `SOC_OFS_PRESET, 32'd5, OK);
    for (int m = 1; m <= 4; m++) begin
      bus(1, `SOC_OFS_CTRL, cw(m, 0, 4, 1, 0), OK);
      cnt(0);
      cnt(5);
      pin(5, ON);
      cause(m, 1);
      pin(5, (m == 1 || m == 3) ? OFF : ON);
      cause(m, 0);
      pin(5, OFF);
    end
    bus(1, `SOC_OFS_CTRL, cw(3, 1, 4, 1, 0), OK);
    pin(5, ON);
    cnt(0);
    cnt(5);
    pin(5, OFF);
    cause(3, 1);
    pin(5, ON);
    cause(3, 0);
    bus(1, `SOC_OFS_DELAY, 32'd59999, OK);
    bus(1, `SOC_OFS_DELAY, 32'd60000, SLV);
    bus(1, `SOC_OFS_DELAY, 32'd5, OK);
    bus(1, `SOC_OFS_DELAY, 32'd0, OK);
    bus(0, `SOC_OFS_DELAY, 32'd5, OK);
    bus(1, `SOC_OFS_CTRL, cw(5, 0, 4, 1, 0), OK);
    cnt(0);
    cnt(5);
    pin(5, ON);
    pin(22, OFF);
    cnt(0);
    cnt(5);
    pin(5, ON);
    cause(3, 1);
    pin(5, OFF);
    cause(3, 0);
    bus(1, `SOC_OFS_CTRL, cw(6, 0, 4, 1, 0), OK);
    for (int k = 0; k < 2; k++) begin
      p = k ? 4 : -3;
      bus(1, `SOC_OFS_PRESET, 32'(p), OK);
      repeat (8) begin
        c = $random(seed) % 8;
        cnt(c);
        pin(5, (p < 0 ? c <= p : c >= p) ? ON : OFF);
      end
    end
    bus(1, `SOC_OFS_CTRL, cw(6, 1, 4, 1, 0), OK);
    cnt(-5);
    pin(5, ON);
    bus(1, `SOC_OFS_PRESET, 32'd5, OK);
    for (int l = 1; l <= 4; l++) begin
      bus(1, `SOC_OFS_CTRL, cw(3, 0, 4, l, 1), OK);
      lk(1);
      bus(1, `SOC_OFS_PRESET, 32'd5, l[0] ? SLV : OK);
      bus(1, `SOC_OFS_SCALE, 32'h2710, l >= 3 ? OK : SLV);
      bus(1, `SOC_OFS_CTRL, cw(3, 0, 4, l, 0), SLV);
      bus(0, `SOC_OFS_CTRL, cw(3, 0, 4, l, 1), OK);
      if (l < 4) lk(0);
    end
    cnt(0);
    cnt(5);
    pin(5, ON);
    cause(3, 1);
    pin(5, ON);
    cause(3, 0);
    lk(0);
    fp_off <= 1'b1;
    fpress <= 1'b1;
    pin(5, ON);
    @(posedge core_clk_i);
    fpress <= 1'b0;
    fp_off <= 1'b0;
    @(posedge core_clk_i);
    fpress <= 1'b1;
    pin(5, OFF);
    @(posedge core_clk_i);
    fpress <= 1'b0;
    for (int z = 1; z <= 4; z++) begin
      lim = 10 ** (6 - z % 4);
      bus(1, `SOC_OFS_CTRL, cw(3, 0, z, 1, 0), OK);
      cnt(lim - 1);
      pin(5, OFF);
      cnt(lim);
      pin(5, 3'h4);
    end
    cnt(0);
    restore <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    pin(3, OFF);
    results();
  end
endmodule
